// ---- adc_ctrl_defines.svh ----
// Register offsets, field positions, reset values and code limits of the ADC control block.
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

`define ADC_CTRL_OFS       8'h00
`define ADC_BIAS_OFS       8'h04
`define ADC_RES_HI_OFS     8'h08
`define ADC_RES_LO_OFS     8'h0c
`define ADC_STATUS_OFS     8'h10

`define CTRL_START_BIT     0
`define CTRL_ALT_BIT       1
`define CTRL_OSR_LSB       2
`define CTRL_NELC_LSB      5

`define BIAS_CONV_LSB      0
`define BIAS_AMP_LSB       2
`define BIAS_CONV_EN_BIT   4
`define BIAS_AMP_EN_BIT    5

`define OSR_RST            3'h0
`define NELC_RST           2'h0
`define BIAS_LEVEL_RST     2'h3
`define ENABLE_RST         1'b0

`define OSR_BASE_LOG2      4'h3
`define CODE_MAX           16'h7fff
`define CODE_MIN           16'h8000
`define RAW_MAX            20'sh07fff
`define RAW_MIN            -20'sh08000

`endif

// ---- adc_ctrl_pkg.sv ----
// Types shared by the ADC control block.
package adc_ctrl_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_INTEG = 3'b010,
      ST_QUANT = 3'b100
   } conv_state_t;

   typedef logic signed [19:0] raw_code_t;

endpackage : adc_ctrl_pkg

// ---- code_fmt_if.sv ----
// Connection between the conversion controller and the output code formatter.
`timescale 1ns/10ps
interface code_fmt_if;
   import adc_ctrl_pkg::*;
   raw_code_t   raw;
   logic [2:0]  osr_sel;
   logic [1:0]  nelc_sel;
   logic [15:0] code;
   modport fmt  (input raw, input osr_sel, input nelc_sel, output code);
   modport user (output raw, output osr_sel, output nelc_sel, input code);
endinterface : code_fmt_if

// ---- code_formatter.sv ----
// Saturates the raw modulator sum and forces the non-significant low bits.
`timescale 1ns/10ps
`include "adc_ctrl_defines.svh"
module code_formatter
   import adc_ctrl_pkg::*;
(
   code_fmt_if.fmt f   // Raw sum and settings in, formatted code out.
);

   function automatic logic [3:0] forced_len(input logic [2:0] o, input logic [1:0] n);
      case ({o, n})
         5'b000_00: forced_len = 4'h9;
         5'b000_01: forced_len = 4'h8;
         5'b000_10: forced_len = 4'h7;
         5'b000_11: forced_len = 4'h7;
         5'b001_00: forced_len = 4'h7;
         5'b001_01: forced_len = 4'h7;
         5'b001_10: forced_len = 4'h6;
         5'b001_11: forced_len = 4'h5;
         5'b010_00: forced_len = 4'h6;
         5'b010_01: forced_len = 4'h5;
         5'b010_10: forced_len = 4'h4;
         5'b010_11: forced_len = 4'h3;
         5'b011_00: forced_len = 4'h4;
         5'b011_01: forced_len = 4'h3;
         5'b011_10: forced_len = 4'h2;
         5'b011_11: forced_len = 4'h1;
         5'b100_00: forced_len = 4'h2;
         5'b100_01: forced_len = 4'h1;
         default:   forced_len = 4'h0;
      endcase
   endfunction : forced_len

   logic [15:0] sat;
   logic [15:0] mask;
   logic [15:0] pat;
   logic [3:0]  k;

   always_comb begin
      if (f.raw > `RAW_MAX) begin
         sat = `CODE_MAX;   // R02
      end else if (f.raw < `RAW_MIN) begin
         sat = `CODE_MIN;   // R02
      end else begin
         sat = f.raw[15:0];   // R01
      end
   end

   assign k    = forced_len(f.osr_sel, f.nelc_sel);   // R04
   assign mask = (16'h0001 << k) - 16'h0001;
   assign pat  = (16'h0001 << k) >> 1;   // R04
   assign f.code = (sat & ~mask) | pat;   // R03

endmodule : code_formatter

// ---- adc_conv_ctrl.sv ----
// APB-controlled conversion sequencer, result registers and bias control of the ADC.
//
// Behaviour
// (R01) Result is sixteen-bit two's complement code.
// (R02) Out-of-range inputs clamp to 0x7FFF or 0x8000.
// (R03) Below sixteen bits, non-significant low bits are forced.
// (R04) Forced pattern is one then zeros, per settings.
// (R05) Result split into high and low byte registers.
// (R06) Software keeps converter bias within sampling limit.
// (R07) Software keeps amplifier bias within sampling limit.
// (R08) Amplifiers and converter can be switched off.
// (R09) Start or alternative trigger bit begins conversion.
// (R10) Oversampling ratio is two to three-plus-field.
// (R11) Elementary conversions are two to the field.
// (R12) Conversion lasts count times ratio-plus-one, plus one.
// (R13) Both result bytes update together at completion.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "adc_ctrl_defines.svh"
module adc_conv_ctrl
   import adc_ctrl_pkg::*;
(
   input  wire logic        pclk,                  // Sampling clock.
   input  wire logic        presetn,               // Asynchronous reset, active low.
   input  wire logic        psel,                  // APB select.
   input  wire logic        penable,               // APB enable.
   input  wire logic        pwrite,                // APB write direction.
   input  wire logic [7:0]  paddr,                 // APB byte address.
   input  wire logic [31:0] pwdata,                // APB write data.
   output logic      [31:0] prdata,                // APB read data.
   output logic             pready,                // APB ready.
   output logic             pslverr,               // APB error on unmapped address.
   input  wire raw_code_t   mod_data,              // Modulator sum at end of conversion.
   output logic             mod_start,             // Pulse: modulator resets for a new run.
   output logic             mod_chop,              // Offset chopping phase.
   output logic             mod_quant,             // Final quantisation cycle.
   output logic             converter_enable,      // Converter powered.
   output logic             amplifier_enable,      // Amplifiers powered.
   output logic      [1:0]  converter_bias_level,  // Converter bias step.
   output logic      [1:0]  amplifier_bias_level,  // Amplifier bias step.
   output logic             conv_busy              // Conversion in progress.
);

   conv_state_t state_ff;
   conv_state_t nxt_state;
   logic [2:0]  osr_sel_ff;
   logic [1:0]  nelc_sel_ff;
   logic [2:0]  osr_run_ff;
   logic [1:0]  nelc_run_ff;
   logic [10:0] el_cnt_ff;
   logic [3:0]  el_idx_ff;
   logic        chop_ff;
   logic [7:0]  res_hi_ff;
   logic [7:0]  res_lo_ff;
   logic [31:0] prdata_ff;
   logic        conv_en_ff;
   logic        amp_en_ff;
   logic [1:0]  conv_bias_ff;
   logic [1:0]  amp_bias_ff;
   logic [10:0] osr_val;
   logic [3:0]  n_val;
   logic        wr_en;
   logic        addr_hit;
   logic        trigger;
   logic        el_end;

   code_fmt_if fmt_bus ();

   code_formatter u_fmt (
      .f (fmt_bus.fmt)
   );

   assign fmt_bus.raw      = mod_data;
   assign fmt_bus.osr_sel  = osr_run_ff;
   assign fmt_bus.nelc_sel = nelc_run_ff;

   assign addr_hit = (paddr == `ADC_CTRL_OFS) || (paddr == `ADC_BIAS_OFS) ||
                     (paddr == `ADC_RES_HI_OFS) || (paddr == `ADC_RES_LO_OFS) ||
                     (paddr == `ADC_STATUS_OFS);
   assign wr_en    = psel && penable && pwrite && addr_hit;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !addr_hit;
   assign prdata   = prdata_ff;

   assign trigger = wr_en && (paddr == `ADC_CTRL_OFS) &&
                    (pwdata[`CTRL_START_BIT] || pwdata[`CTRL_ALT_BIT]);   // R09

   assign osr_val = 11'h001 << (`OSR_BASE_LOG2 + {1'b0, osr_run_ff});   // R10
   assign n_val   = 4'h1 << nelc_run_ff;   // R11
   assign el_end  = (el_cnt_ff == osr_val);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osr_sel_ff  <= `OSR_RST;
         nelc_sel_ff <= `NELC_RST;
      end else if (wr_en && paddr == `ADC_CTRL_OFS) begin
         osr_sel_ff  <= pwdata[`CTRL_OSR_LSB +: 3];
         nelc_sel_ff <= pwdata[`CTRL_NELC_LSB +: 2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_bias_ff <= `BIAS_LEVEL_RST;
         amp_bias_ff  <= `BIAS_LEVEL_RST;
         conv_en_ff   <= `ENABLE_RST;
         amp_en_ff    <= `ENABLE_RST;
      end else if (wr_en && paddr == `ADC_BIAS_OFS) begin
         conv_bias_ff <= pwdata[`BIAS_CONV_LSB +: 2];   // R06
         amp_bias_ff  <= pwdata[`BIAS_AMP_LSB +: 2];   // R07
         conv_en_ff   <= pwdata[`BIAS_CONV_EN_BIT];   // R08
         amp_en_ff    <= pwdata[`BIAS_AMP_EN_BIT];   // R08
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE:  if (trigger && conv_en_ff) nxt_state = ST_INTEG;   // R09
         ST_INTEG: if (el_end && (el_idx_ff + 4'h1 == n_val)) nxt_state = ST_QUANT;   // R12
         ST_QUANT: nxt_state = ST_IDLE;
         default:  nxt_state = ST_IDLE;
      endcase
      if (!conv_en_ff) begin
         nxt_state = ST_IDLE;   // R08
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Settings are frozen for the whole run so a rewrite cannot skew the count.
   // A start is always a control write, so the settings written with it are the ones used.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osr_run_ff  <= `OSR_RST;
         nelc_run_ff <= `NELC_RST;
      end else if (state_ff == ST_IDLE && nxt_state == ST_INTEG) begin
         osr_run_ff  <= pwdata[`CTRL_OSR_LSB +: 3];   // R10
         nelc_run_ff <= pwdata[`CTRL_NELC_LSB +: 2];   // R11
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         el_cnt_ff <= 11'h000;
         el_idx_ff <= 4'h0;
         chop_ff   <= 1'b0;
      end else if (state_ff != ST_INTEG) begin
         el_cnt_ff <= 11'h000;
         el_idx_ff <= 4'h0;
         chop_ff   <= 1'b0;
      end else if (el_end) begin
         el_cnt_ff <= 11'h000;   // R12
         el_idx_ff <= el_idx_ff + 4'h1;   // R11
         chop_ff   <= !chop_ff;
      end else begin
         el_cnt_ff <= el_cnt_ff + 11'h001;   // R10
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_hi_ff <= 8'h00;
         res_lo_ff <= 8'h00;
      end else if (state_ff == ST_QUANT) begin
         res_hi_ff <= fmt_bus.code[15:8];   // R05 R13
         res_lo_ff <= fmt_bus.code[7:0];   // R05 R13
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `ADC_CTRL_OFS:   prdata_ff <= {25'h0, nelc_sel_ff, osr_sel_ff, 2'b00};
            `ADC_BIAS_OFS:   prdata_ff <= {26'h0, amp_en_ff, conv_en_ff,
                                           amp_bias_ff, conv_bias_ff};
            `ADC_RES_HI_OFS: prdata_ff <= {24'h0, res_hi_ff};   // R05
            `ADC_RES_LO_OFS: prdata_ff <= {24'h0, res_lo_ff};   // R05
            `ADC_STATUS_OFS: prdata_ff <= {31'h0, state_ff != ST_IDLE};
            default:         prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign mod_start            = (state_ff == ST_IDLE) && (nxt_state == ST_INTEG);
   assign mod_chop             = chop_ff;
   assign mod_quant            = (state_ff == ST_QUANT);
   assign conv_busy            = (state_ff != ST_IDLE);
   assign converter_enable     = conv_en_ff;
   assign amplifier_enable     = amp_en_ff;
   assign converter_bias_level = conv_bias_ff;
   assign amplifier_bias_level = amp_bias_ff;

   // Checking helpers: run length and its expected value from the frozen settings.
   logic [13:0] len_ff;
   logic [13:0] len_exp;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len_ff <= 14'h0000;
      end else if (state_ff == ST_IDLE) begin
         len_ff <= 14'h0000;
      end else begin
         len_ff <= len_ff + 14'h0001;
      end
   end

   assign len_exp = 14'(((32'h1 << (3 + osr_run_ff)) + 32'h1) * (32'h1 << nelc_run_ff));

   sequence s_trigger;
      (state_ff == ST_IDLE) && trigger && conv_en_ff;
   endsequence

   sequence s_capture;
      (state_ff == ST_QUANT) && conv_en_ff;
   endsequence

   AST_START_RUNS: assert property (@(posedge pclk) disable iff (!presetn)   // R09
      s_trigger |=> (state_ff == ST_INTEG) && (el_cnt_ff == 11'h000) ##1 conv_busy)
      else $error("Trigger did not start a conversion.");

   AST_CONV_LENGTH: assert property (@(posedge pclk) disable iff (!presetn)   // R12
      (state_ff == ST_QUANT) |-> (len_ff == len_exp))
      else $error("Conversion length differs from the expected count.");

   AST_OSR_BOUND: assert property (@(posedge pclk) disable iff (!presetn)   // R10
      (state_ff == ST_INTEG) |-> (el_cnt_ff <= osr_val) && (osr_val >= 11'd8))
      else $error("Integration counter passed the oversampling ratio.");

   AST_ELEM_BOUND: assert property (@(posedge pclk) disable iff (!presetn)   // R11
      (state_ff == ST_INTEG) |-> (el_idx_ff < n_val) && (n_val <= 4'h8))
      else $error("Elementary count passed its setting.");

   AST_SAT_POS: assert property (@(posedge pclk) disable iff (!presetn)   // R02
      s_capture and (mod_data > `RAW_MAX) |=> (res_hi_ff == 8'h7f))
      else $error("Positive overflow did not clamp to full scale.");

   AST_SAT_NEG: assert property (@(posedge pclk) disable iff (!presetn)   // R02
      s_capture and (mod_data < `RAW_MIN) |=> (res_hi_ff[7:1] == 7'h40))
      else $error("Negative overflow did not clamp to full scale.");

   AST_FORCE_NINE: assert property (@(posedge pclk) disable iff (!presetn)   // R04
      s_capture and (osr_run_ff == 3'h0) && (nelc_run_ff == 2'h0)
      |=> (res_lo_ff == 8'h00) && res_hi_ff[0])
      else $error("Nine-bit forced pattern missing.");

   AST_FORCE_ONE: assert property (@(posedge pclk) disable iff (!presetn)   // R03
      s_capture and (osr_run_ff == 3'h3) && (nelc_run_ff == 2'h3) |=> res_lo_ff[0])
      else $error("One-bit forced pattern missing.");

   AST_FULL_RES: assert property (@(posedge pclk) disable iff (!presetn)   // R01
      s_capture and (osr_run_ff >= 3'h5) and (mod_data <= `RAW_MAX) and (mod_data >= `RAW_MIN)
      |=> ({res_hi_ff, res_lo_ff} == $past(mod_data[15:0])))
      else $error("Full-resolution result altered.");

   AST_RES_HOLD: assert property (@(posedge pclk) disable iff (!presetn)   // R13
      (state_ff != ST_QUANT) |=> $stable(res_hi_ff) && $stable(res_lo_ff))
      else $error("Result bytes changed outside completion.");

   AST_POWER_OFF: assert property (@(posedge pclk) disable iff (!presetn)   // R08
      !conv_en_ff |=> (state_ff == ST_IDLE) && !mod_quant)
      else $error("Conversion ran while the converter was off.");

endmodule : adc_conv_ctrl

// ---- adc_modulator_model.sv ----
// Behavioural modulator that returns a preset sum in the quantisation cycle.
`timescale 1ns/10ps
module adc_modulator_model
   import adc_ctrl_pkg::*;
(
   input  wire logic      pclk,      // Sampling clock.
   input  wire logic      mod_quant, // Quantisation cycle.
   input  wire raw_code_t sum_value, // Sum to hand back.
   output raw_code_t      mod_data   // Modulator sum.
);
   raw_code_t last_ff = '0;
   // Outside the quantisation cycle the sum is not valid, so a moving pattern shows.
   always @(posedge pclk) begin
      last_ff <= ~last_ff;
   end
   assign mod_data = mod_quant ? sum_value : last_ff;
endmodule : adc_modulator_model

// ---- tb_adc_conv_ctrl.sv ----
// Self-checking testbench of the ADC control block.
`timescale 1ns/10ps
`include "adc_ctrl_defines.svh"
module tb_adc_conv_ctrl
   import adc_ctrl_pkg::*;
;
   typedef struct {
      logic [2:0]  osr;
      logic [1:0]  nelc;
      logic        alt;
      raw_code_t   raw;
      logic [15:0] code;
      int          dur;
   } row_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        mod_start, mod_chop, mod_quant, converter_enable, amplifier_enable, conv_busy;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  converter_bias_level, amplifier_bias_level;
   raw_code_t   mod_data, sum_value;
   int          fail_count = 0;
   int          checks = 0;
   int          cycles = 0;
   int          starts = 0;
   row_t        rows[8] = '{
      '{3'h0, 2'h0, 1'b0, 20'h12345, 16'h7f00, 10},
      '{3'h1, 2'h3, 1'b0, 20'hf0000, 16'h8010, 137},
      '{3'h3, 2'h3, 1'b0, 20'h01234, 16'h1235, 521},
      '{3'h4, 2'h1, 1'b1, 20'hffffe, 16'hffff, 259},
      '{3'h2, 2'h2, 1'b0, 20'h00abc, 16'h0ab8, 133},
      '{3'h4, 2'h2, 1'b1, 20'h05a5a, 16'h5a5a, 517},
      '{3'h5, 2'h0, 1'b0, 20'hf8765, 16'h8765, 258},
      '{3'h0, 2'h1, 1'b1, 20'h07fff, 16'h7f80, 19}};

   adc_conv_ctrl i_adc_conv_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mod_data(mod_data), .mod_start(mod_start), .mod_chop(mod_chop), .mod_quant(mod_quant),
      .converter_enable(converter_enable), .amplifier_enable(amplifier_enable),
      .converter_bias_level(converter_bias_level),
      .amplifier_bias_level(amplifier_bias_level), .conv_busy(conv_busy));

   adc_modulator_model i_adc_modulator_model (
      .pclk(pclk), .mod_quant(mod_quant), .sum_value(sum_value), .mod_data(mod_data));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task finish_test;
      $display("Checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   // Start pulses are counted at the edge that takes them.
   always @(posedge pclk) begin
      if (mod_start === 1'b1) begin
         starts <= starts + 1;
      end
   end

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One APB transfer; read data and error are taken at the edge where pready is high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task convert(input row_t r);
      int n;
      int q;
      int t;
      int s0;
      logic c;
      n = 0;
      q = 0;
      t = 0;
      s0 = starts;
      sum_value = r.raw;
      apb(1'b1, `ADC_CTRL_OFS, {25'h0, r.nelc, r.osr, r.alt, ~r.alt});
      @(negedge pclk);
      c = mod_chop;
      while (conv_busy === 1'b1) begin
         n++;
         if (mod_quant === 1'b1) begin
            q++;
         end
         if (mod_chop !== c) begin
            t++;
         end
         c = mod_chop;
         @(negedge pclk);
      end
      chk("busy cycles", r.dur, n);
      chk("start pulses", 32'h1, starts - s0);
      chk("quantisation cycles", 32'h1, q);
      chk("chop phases", 32'h1 << r.nelc, t);
      chk("chop idle", 32'h0, {31'h0, mod_chop});
      apb(1'b0, `ADC_RES_HI_OFS, 32'h0);
      chk("result high byte", {24'h0, r.code[15:8]}, rd);
      apb(1'b0, `ADC_RES_LO_OFS, 32'h0);
      chk("result low byte", {24'h0, r.code[7:0]}, rd);
   endtask : convert

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sum_value = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `ADC_BIAS_OFS, 32'h0);
      chk("bias reset", 32'h0000000f, rd);
      apb(1'b0, `ADC_RES_HI_OFS, 32'h0);
      chk("result reset", 32'h0, rd);
      apb(1'b1, `ADC_CTRL_OFS, 32'h1);
      @(negedge pclk);
      chk("busy while off", 32'h0, {31'h0, conv_busy});
      apb(1'b1, `ADC_BIAS_OFS, 32'h39);
      @(negedge pclk);
      chk("bias ports", 32'h39, {26'h0, amplifier_enable, converter_enable,
          amplifier_bias_level, converter_bias_level});
      foreach (rows[i]) begin
         convert(rows[i]);
      end
      chk("ready level", 32'h1, {31'h0, pready});
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      apb(1'b1, `ADC_RES_HI_OFS, 32'hff);
      apb(1'b0, `ADC_RES_HI_OFS, 32'h0);
      chk("read-only high byte", 32'h7f, rd);
      apb(1'b1, `ADC_CTRL_OFS, 32'h7d);
      repeat (20) @(posedge pclk);
      chk("busy long run", 32'h1, {31'h0, conv_busy});
      apb(1'b0, `ADC_STATUS_OFS, 32'h0);
      chk("status busy", 32'h1, rd);
      apb(1'b0, `ADC_CTRL_OFS, 32'h0);
      chk("control readback", 32'h7c, rd);
      apb(1'b1, `ADC_BIAS_OFS, 32'h0);
      repeat (2) @(negedge pclk);
      chk("busy after power off", 32'h0, {31'h0, conv_busy});
      apb(1'b0, `ADC_RES_LO_OFS, 32'h0);
      chk("low byte after abort", 32'h80, rd);
      apb(1'b1, `ADC_BIAS_OFS, 32'h39);
      apb(1'b1, `ADC_CTRL_OFS, 32'h01);
      repeat (5) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("busy in reset", 32'h0, {31'h0, conv_busy});
      presetn <= 1'b1;
      apb(1'b0, `ADC_RES_LO_OFS, 32'h0);
      chk("low byte after reset", 32'h0, rd);
      apb(1'b0, `ADC_BIAS_OFS, 32'h0);
      chk("bias after reset", 32'h0000000f, rd);
      finish_test();
   end
endmodule : tb_adc_conv_ctrl
